// [inc/timer_pkg.sv]
// constants, codes and carriers of the timer core
package timer_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;

    // register word offsets
    localparam logic [7:0] OFS_CNT_CFG = 8'h00;
    localparam logic [7:0] OFS_MODE_CFG = 8'h04;
    localparam logic [7:0] OFS_TRIG_CFG = 8'h08;
    localparam logic [7:0] OFS_EVENT_GEN = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_COUNTER = 8'h14;
    localparam logic [7:0] OFS_PRESCALER = 8'h18;
    localparam logic [7:0] OFS_RELOAD = 8'h1C;

    // counter_config_reg fields
    localparam int CFG_CMS_LSB = 0;
    localparam int CFG_DIR_BIT = 2;
    localparam int CFG_INHIBIT_BIT = 3;
    localparam int CFG_ENABLE_BIT = 4;
    // mode_config_reg fields
    localparam int MODE_SMS_LSB = 0;
    // trigger_config_reg fields
    localparam int TRG_TSEL_LSB = 0;
    localparam int TRG_EXT_CLOCK_MODE_EN_BIT = 8;
    localparam int TRG_POL_BIT = 9;
    localparam int TRG_PSC_LSB = 12;
    localparam int TRG_FLT_LSB = 16;
    // event_generate_reg and interrupt_status_reg fields
    localparam int EVG_UPDATE_BIT = 0;
    localparam int STS_UPDATE_BIT = 0;
    localparam int STS_TRIGGER_BIT = 1;

    // reset values
    localparam logic [CNT_W-1:0] RST_RELOAD = 16'hFFFF;
    localparam logic [CNT_W-1:0] RST_PRESCALER = 16'h0000;
    localparam logic [CNT_W-1:0] RST_COUNTER = 16'h0000;

    // slave_mode_sel codes
    localparam logic [2:0] SMS_OFF = 3'h0;
    localparam logic [2:0] SMS_ENC_CH0 = 3'h1;
    localparam logic [2:0] SMS_ENC_CH1 = 3'h2;
    localparam logic [2:0] SMS_ENC_BOTH = 3'h3;
    localparam logic [2:0] SMS_RESTART = 3'h4;
    localparam logic [2:0] SMS_PAUSE = 3'h5;
    localparam logic [2:0] SMS_TRIGGER = 3'h6;
    localparam logic [2:0] SMS_EVENT_CNT = 3'h7;

    // trigger_source_sel codes
    localparam logic [2:0] TS_SOFT = 3'h0;
    localparam logic [2:0] TS_CH0 = 3'h1;
    localparam logic [2:0] TS_CH1 = 3'h2;
    localparam logic [2:0] TS_EXT = 3'h3;
    localparam logic [2:0] TS_CH0_BOTH = 3'h4;
    localparam logic [2:0] TS_INT0 = 3'h5;
    localparam logic [2:0] TS_INT1 = 3'h6;
    localparam logic [2:0] TS_INT2 = 3'h7;

    // center_mode_sel codes
    localparam logic [1:0] CMS_EDGE = 2'h0;
    localparam logic [1:0] CMS_FALL = 2'h1;
    localparam logic [1:0] CMS_RISE = 2'h2;
    localparam logic [1:0] CMS_BOTH = 2'h3;

    typedef struct packed {
        logic [1:0] centerModeSel;
        logic updateEventInhibit;
        logic counterEnable;
    } cnt_cfg_s;

    typedef struct packed {
        logic [2:0] triggerSourceSel;
        logic extClockModeEn;
        logic extTriggerPolarity;
        logic [1:0] extTriggerPrescale;
        logic [3:0] extTriggerFilterSel;
    } trig_cfg_s;

    function automatic logic isEncoder(input logic [2:0] sms);
        isEncoder = (sms == SMS_ENC_CH0) || (sms == SMS_ENC_CH1) ||
            (sms == SMS_ENC_BOTH);
    endfunction : isEncoder

endpackage : timer_pkg

// [logic/ext_trigger_cond.sv]
// external trigger pin conditioning: polarity, divider, digital filter
`timescale 1ns/1ps
module ext_trigger_cond import timer_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    input wire logic clkEnable,
    // pin and config
    input wire logic extTriggerPin,
    input wire logic polarity,
    input wire logic [1:0] prescale,
    input wire logic [3:0] filterSel,
    // conditioned level
    output logic filteredLevel
);

    logic polLevel;
    logic prev_reg;
    logic [2:0] div_reg;
    logic divLevel;
    logic [3:0] stable_reg;
    logic filt_reg;

    assign polLevel = extTriggerPin ^ polarity;
    assign filteredLevel = filt_reg;

    // a 3-bit edge count gives divide by 1, 2, 4 or 8
    always_comb
    begin
        case (prescale)
            2'h0: divLevel = polLevel;
            2'h1: divLevel = div_reg[0];
            2'h2: divLevel = div_reg[1];
            default: divLevel = div_reg[2];
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            prev_reg <= 1'b0;
            div_reg <= 3'h0;
        end
        else if (clkEnable)
        begin
            prev_reg <= polLevel;
            if (polLevel && !prev_reg)
                div_reg <= div_reg + 3'h1;
        end
    end

    // new level must persist filterSel+1 samples
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            stable_reg <= 4'h0;
            filt_reg <= 1'b0;
        end
        else if (clkEnable)
        begin
            if (divLevel == filt_reg)
                stable_reg <= 4'h0;
            else if (stable_reg >= filterSel)
            begin
                filt_reg <= divLevel;
                stable_reg <= 4'h0;
            end
            else
                stable_reg <= stable_reg + 4'h1;
        end
    end

endmodule : ext_trigger_cond

// [logic/timer_core.sv]
// 16-bit timer with clock selection and slave controller
`timescale 1ns/1ps
module timer_core import timer_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    input wire logic clkEnable,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regRdata,
    // pins and other timers
    input wire logic channel0Pin,
    input wire logic channel1Pin,
    input wire logic extTriggerPin,
    input wire logic ch0BothEdgeSignal,
    input wire logic [2:0] internalTrigger,
    // status
    output logic [CNT_W-1:0] counterValue,
    output logic overflowPulse,
    output logic underflowPulse,
    output logic updateEventPulse,
    output logic triggerPulse
);

    cnt_cfg_s cntCfg_reg;
    trig_cfg_s trigCfg_reg;
    logic [2:0] slaveMode_reg;
    logic dir_reg, dir_next;
    logic [CNT_W-1:0] count_reg, count_next;
    logic [CNT_W-1:0] pscPre_reg, pscShadow_reg, pscCnt_reg;
    logic [CNT_W-1:0] reloadPre_reg, reloadShadow_reg;
    logic updFlag_reg, trgFlag_reg;
    logic ch0Prev_reg, ch1Prev_reg, stiPrev_reg, extPrev_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic ovf_reg, udf_reg, updPulse_reg, trgPulse_reg;

    logic extFiltered;
    logic wrCntCfg, wrMode, wrTrig, wrStatus, wrCounter, wrPsc, wrReload;
    logic softUpdate, stiLevel, stiEdge, extEdge, ch0Edge, ch1Edge;
    logic encMode, encTick, encUp, centerMode, clockSource, run, tick;
    logic restartEdge, reinit, transfer, flagWrap, ovf, udf, effDir;
    logic [CNT_W-1:0] reloadEff;
    logic [DATA_W-1:0] readValue;

    ext_trigger_cond extCond (
        .mclk(mclk),
        .reset(reset),
        .clkEnable(clkEnable),
        .extTriggerPin(extTriggerPin),
        .polarity(trigCfg_reg.extTriggerPolarity),
        .prescale(trigCfg_reg.extTriggerPrescale),
        .filterSel(trigCfg_reg.extTriggerFilterSel),
        .filteredLevel(extFiltered)
    );

    function automatic logic hit(input logic [ADDR_W-1:0] ofs);
        hit = regWrite && (regAddr == ofs);
    endfunction : hit

    assign wrCntCfg = hit(OFS_CNT_CFG);
    assign wrMode = hit(OFS_MODE_CFG);
    assign wrTrig = hit(OFS_TRIG_CFG);
    assign wrStatus = hit(OFS_STATUS);
    assign wrCounter = hit(OFS_COUNTER);
    assign wrPsc = hit(OFS_PRESCALER);
    assign wrReload = hit(OFS_RELOAD);
    assign softUpdate = hit(OFS_EVENT_GEN) && regWdata[EVG_UPDATE_BIT];

    // slave trigger select; soft source has no level
    always_comb
    begin
        case (trigCfg_reg.triggerSourceSel)
            TS_CH0: stiLevel = channel0Pin;
            TS_CH1: stiLevel = channel1Pin;
            TS_EXT: stiLevel = extFiltered;
            TS_CH0_BOTH: stiLevel = ch0BothEdgeSignal;
            TS_INT0: stiLevel = internalTrigger[0];
            TS_INT1: stiLevel = internalTrigger[1];
            TS_INT2: stiLevel = internalTrigger[2];
            default: stiLevel = 1'b0;
        endcase
    end

    assign stiEdge = stiLevel && !stiPrev_reg &&
        (trigCfg_reg.triggerSourceSel != TS_SOFT);
    assign extEdge = extFiltered && !extPrev_reg;
    assign ch0Edge = channel0Pin ^ ch0Prev_reg;
    assign ch1Edge = channel1Pin ^ ch1Prev_reg;
    assign encMode = isEncoder(slaveMode_reg);
    assign centerMode = (cntCfg_reg.centerModeSel != CMS_EDGE);

    // quadrature source per code
    always_comb
    begin
        case (slaveMode_reg)
            SMS_ENC_CH0: encTick = ch0Edge;
            SMS_ENC_CH1: encTick = ch1Edge;
            SMS_ENC_BOTH: encTick = ch0Edge || ch1Edge;
            default: encTick = 1'b0;
        endcase
    end

    assign encUp = ch0Edge ? (channel0Pin != channel1Pin)
        : (channel1Pin == channel0Pin);

    // prescaler clock source selection
    always_comb
    begin
        if (trigCfg_reg.extClockModeEn)
            clockSource = extEdge;
        else
        begin
            case (slaveMode_reg)
                SMS_ENC_CH0, SMS_ENC_CH1, SMS_ENC_BOTH:
                    clockSource = encTick;
                SMS_EVENT_CNT:
                    clockSource = stiEdge;
                default:
                    clockSource = 1'b1;
            endcase
        end
    end

    // pause ignores the both-edge source
    assign run = cntCfg_reg.counterEnable &&
        (slaveMode_reg != SMS_PAUSE || stiLevel ||
        trigCfg_reg.triggerSourceSel == TS_CH0_BOTH);
    assign tick = clockSource && run &&
        (pscCnt_reg == pscShadow_reg);

    assign restartEdge = (slaveMode_reg == SMS_RESTART) && stiEdge;
    // soft source in event mode only updates
    assign reinit = softUpdate || restartEdge;
    assign transfer = (reinit || ovf || udf) &&
        !cntCfg_reg.updateEventInhibit;
    assign flagWrap = (ovf && cntCfg_reg.centerModeSel != CMS_FALL) ||
        (udf && cntCfg_reg.centerModeSel != CMS_RISE);
    assign reloadEff = cntCfg_reg.updateEventInhibit ? reloadShadow_reg
        : reloadPre_reg;
    assign effDir = (encMode && encTick) ? !encUp : dir_reg;

    // next count and wraps
    always_comb
    begin
        count_next = count_reg;
        dir_next = dir_reg;
        ovf = 1'b0;
        udf = 1'b0;
        if (wrCntCfg && !centerMode && !encMode)
            dir_next = regWdata[CFG_DIR_BIT];
        else if (encMode && encTick)
            dir_next = effDir;
        if (reinit)
        begin
            if (!centerMode && dir_reg)
                count_next = reloadEff;
            else
                count_next = RST_COUNTER;
            if (centerMode)
                dir_next = 1'b0;
        end
        else if (wrCounter)
            count_next = regWdata[CNT_W-1:0];
        else if (tick)
        begin
            if (centerMode)
            begin
                if (!dir_reg)
                begin
                    if (count_reg + 16'h0001 >= reloadShadow_reg)
                    begin
                        count_next = reloadShadow_reg;
                        ovf = 1'b1;
                        dir_next = 1'b1;
                    end
                    else
                        count_next = count_reg + 16'h0001;
                end
                else if (count_reg <= 16'h0001)
                begin
                    count_next = RST_COUNTER;
                    udf = 1'b1;
                    dir_next = 1'b0;
                end
                else
                    count_next = count_reg - 16'h0001;
            end
            else if (!effDir)
            begin
                if (count_reg >= reloadShadow_reg)
                begin
                    count_next = RST_COUNTER;
                    ovf = 1'b1;
                end
                else
                    count_next = count_reg + 16'h0001;
            end
            else if (count_reg == RST_COUNTER)
            begin
                count_next = reloadEff;
                udf = 1'b1;
            end
            else
                count_next = count_reg - 16'h0001;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            count_reg <= RST_COUNTER;
            dir_reg <= 1'b0;
        end
        else if (clkEnable)
        begin
            count_reg <= count_next;
            dir_reg <= dir_next;
        end
    end

    // prescaler restarts on reinit
    always_ff @(posedge mclk)
    begin
        if (reset)
            pscCnt_reg <= 16'h0000;
        else if (clkEnable)
        begin
            if (reinit || tick)
                pscCnt_reg <= 16'h0000;
            else if (clockSource && run)
                pscCnt_reg <= pscCnt_reg + 16'h0001;
        end
    end

    // preloads and shadows
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pscPre_reg <= RST_PRESCALER;
            pscShadow_reg <= RST_PRESCALER;
            reloadPre_reg <= RST_RELOAD;
            reloadShadow_reg <= RST_RELOAD;
        end
        else if (clkEnable)
        begin
            if (wrPsc)
                pscPre_reg <= regWdata[CNT_W-1:0];
            if (wrReload)
                reloadPre_reg <= regWdata[CNT_W-1:0];
            if (transfer)
            begin
                pscShadow_reg <= pscPre_reg;
                reloadShadow_reg <= reloadPre_reg;
            end
        end
    end

    // configuration; trigger mode can only start the counter
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            cntCfg_reg <= '0;
            trigCfg_reg <= '0;
            slaveMode_reg <= SMS_OFF;
        end
        else if (clkEnable)
        begin
            if (wrCntCfg)
            begin
                cntCfg_reg.centerModeSel <=
                    regWdata[CFG_CMS_LSB +: 2];
                cntCfg_reg.updateEventInhibit <=
                    regWdata[CFG_INHIBIT_BIT];
                cntCfg_reg.counterEnable <= regWdata[CFG_ENABLE_BIT];
            end
            if (slaveMode_reg == SMS_TRIGGER && stiEdge)
                cntCfg_reg.counterEnable <= 1'b1;
            if (wrMode)
                slaveMode_reg <= regWdata[MODE_SMS_LSB +: 3];
            if (wrTrig)
            begin
                trigCfg_reg.triggerSourceSel <=
                    regWdata[TRG_TSEL_LSB +: 3];
                trigCfg_reg.extClockModeEn <= regWdata[TRG_EXT_CLOCK_MODE_EN_BIT];
                trigCfg_reg.extTriggerPolarity <= regWdata[TRG_POL_BIT];
                trigCfg_reg.extTriggerPrescale <=
                    regWdata[TRG_PSC_LSB +: 2];
                trigCfg_reg.extTriggerFilterSel <=
                    regWdata[TRG_FLT_LSB +: 4];
            end
        end
    end

    // write-one-to-clear flags; set wins
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            updFlag_reg <= 1'b0;
            trgFlag_reg <= 1'b0;
        end
        else if (clkEnable)
        begin
            if (transfer && (reinit || flagWrap))
                updFlag_reg <= 1'b1;
            else if (wrStatus && regWdata[STS_UPDATE_BIT])
                updFlag_reg <= 1'b0;
            if (stiEdge && slaveMode_reg >= SMS_RESTART)
                trgFlag_reg <= 1'b1;
            else if (wrStatus && regWdata[STS_TRIGGER_BIT])
                trgFlag_reg <= 1'b0;
        end
    end

    // edge history
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ch0Prev_reg <= 1'b0;
            ch1Prev_reg <= 1'b0;
            stiPrev_reg <= 1'b0;
            extPrev_reg <= 1'b0;
        end
        else if (clkEnable)
        begin
            ch0Prev_reg <= channel0Pin;
            ch1Prev_reg <= channel1Pin;
            stiPrev_reg <= stiLevel;
            extPrev_reg <= extFiltered;
        end
    end

    // registered event pulses
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ovf_reg <= 1'b0;
            udf_reg <= 1'b0;
            updPulse_reg <= 1'b0;
            trgPulse_reg <= 1'b0;
        end
        else if (clkEnable)
        begin
            ovf_reg <= ovf;
            udf_reg <= udf;
            updPulse_reg <= transfer;
            trgPulse_reg <= stiEdge;
        end
        else
        begin
            ovf_reg <= 1'b0;
            udf_reg <= 1'b0;
            updPulse_reg <= 1'b0;
            trgPulse_reg <= 1'b0;
        end
    end

    // read mux; unmapped reads 0
    always_comb
    begin
        readValue = '0;
        case (regAddr)
            OFS_CNT_CFG:
            begin
                readValue[CFG_CMS_LSB +: 2] = cntCfg_reg.centerModeSel;
                readValue[CFG_DIR_BIT] = dir_reg;
                readValue[CFG_INHIBIT_BIT] = cntCfg_reg.updateEventInhibit;
                readValue[CFG_ENABLE_BIT] = cntCfg_reg.counterEnable;
            end
            OFS_MODE_CFG: readValue[MODE_SMS_LSB +: 3] = slaveMode_reg;
            OFS_TRIG_CFG:
            begin
                readValue[TRG_TSEL_LSB +: 3] = trigCfg_reg.triggerSourceSel;
                readValue[TRG_EXT_CLOCK_MODE_EN_BIT] = trigCfg_reg.extClockModeEn;
                readValue[TRG_POL_BIT] = trigCfg_reg.extTriggerPolarity;
                readValue[TRG_PSC_LSB +: 2] = trigCfg_reg.extTriggerPrescale;
                readValue[TRG_FLT_LSB +: 4] =
                    trigCfg_reg.extTriggerFilterSel;
            end
            OFS_STATUS:
            begin
                readValue[STS_UPDATE_BIT] = updFlag_reg;
                readValue[STS_TRIGGER_BIT] = trgFlag_reg;
            end
            OFS_COUNTER: readValue[CNT_W-1:0] = count_reg;
            OFS_PRESCALER: readValue[CNT_W-1:0] = pscPre_reg;
            OFS_RELOAD: readValue[CNT_W-1:0] = reloadPre_reg;
            default: readValue = '0;
        endcase
    end

    // read data stand one cycle
    always_ff @(posedge mclk)
    begin
        if (reset)
            rdata_reg <= '0;
        else if (clkEnable)
            rdata_reg <= regRead ? readValue : '0;
    end

    assign regRdata = rdata_reg;
    assign counterValue = count_reg;
    assign overflowPulse = ovf_reg;
    assign underflowPulse = udf_reg;
    assign updateEventPulse = updPulse_reg;
    assign triggerPulse = trgPulse_reg;

endmodule : timer_core

// [testbench/timer_core_assertions.sv]
// port checks for the timer core
`timescale 1ns/1ps
module timer_core_checker import timer_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    input wire logic clkEnable,
    // register writes
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWrite,
    // status
    input wire logic [CNT_W-1:0] counterValue,
    input wire logic overflowPulse,
    input wire logic underflowPulse,
    input wire logic updateEventPulse,
    input wire logic triggerPulse
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    logic inhibitReg;
    logic softReq;
    // soft update must pulse when not inhibited
    always_ff @(posedge mclk)
    begin
        if (reset)
            inhibitReg <= 1'b0;
        else if (regWrite && clkEnable && regAddr == OFS_CNT_CFG)
            inhibitReg <= regWdata[CFG_INHIBIT_BIT];
    end
    assign softReq = regWrite && clkEnable && !inhibitReg &&
        regAddr == OFS_EVENT_GEN && regWdata[EVG_UPDATE_BIT];
    chk_ovf_one_cycle: assert property (
        overflowPulse |=> !overflowPulse) else $error("long overflow");
    chk_unf_one_cycle: assert property (
        underflowPulse |=> !underflowPulse) else $error("long underflow");
    chk_trig_one_cycle: assert property (
        triggerPulse |=> !triggerPulse) else $error("long trigger");
    chk_wrap_exclusive: assert property (
        !(overflowPulse && underflowPulse)) else $error("both wraps");
    chk_reset_values: assert property (
        $fell(reset) |-> counterValue == RST_COUNTER && !overflowPulse &&
        !updateEventPulse) else $error("bad reset state");
    chk_freeze_hold: assert property (
        !clkEnable |=> $stable(counterValue)) else $error("moved frozen");
    chk_freeze_quiet: assert property (
        !clkEnable |=> !overflowPulse && !underflowPulse && !triggerPulse)
        else $error("pulse while frozen");
    chk_soft_update: assert property (
        softReq |-> ##[1:2] updateEventPulse) else $error("no update");
    cover property (overflowPulse);
    cover property (underflowPulse);
    cover property (triggerPulse);
endmodule : timer_core_checker
bind timer_core timer_core_checker chk (.mclk, .reset, .clkEnable,
    .regAddr, .regWdata, .regWrite, .counterValue, .overflowPulse,
    .underflowPulse, .updateEventPulse, .triggerPulse);

// [testbench/trigger_source_model.sv]
// far side: encoder channels, trigger pin and neighbour timers
`timescale 1ns/1ps
module trigger_source_model (
    // clock
    input wire logic mclk,
    // driven lines
    output logic channel0Pin,
    output logic channel1Pin,
    output logic extTriggerPin,
    output logic ch0BothEdgeSignal,
    output logic [2:0] internalTrigger
);
    logic [6:0] lines = 7'h00;
    assign {internalTrigger, ch0BothEdgeSignal, extTriggerPin, channel1Pin,
        channel0Pin} = lines;
    task automatic pulse(input int idx, input int hi, input int lo);
        @(posedge mclk);
        lines[idx] <= 1'b1;
        repeat (hi) @(posedge mclk);
        lines[idx] <= 1'b0;
        repeat (lo) @(posedge mclk);
    endtask : pulse
    // forward quadrature steps; 4n ends at 00
    task automatic quad(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk);
            lines[i % 2] <= !lines[i % 2];
            repeat (3) @(posedge mclk);
        end
    endtask : quad
endmodule : trigger_source_model

// [testbench/timer_core_tb_top.sv]
// self-checking bench for the timer core
`timescale 1ns/1ps
module timer_core_tb_top import timer_pkg::*;;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic clkEnable = 1'b1;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWdata = '0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [DATA_W-1:0] regRdata, d;
    logic channel0Pin, channel1Pin, extTriggerPin, ch0BothEdgeSignal;
    logic [2:0] internalTrigger;
    logic [CNT_W-1:0] counterValue;
    logic overflowPulse, underflowPulse, updateEventPulse, triggerPulse;
    logic [3:0] pulses;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;
    assign pulses = {triggerPulse, updateEventPulse, underflowPulse,
        overflowPulse};
    timer_core uut (.mclk, .reset, .clkEnable, .regAddr, .regWdata,
        .regWrite, .regRead, .regRdata, .channel0Pin, .channel1Pin,
        .extTriggerPin, .ch0BothEdgeSignal, .internalTrigger, .counterValue,
        .overflowPulse, .underflowPulse, .updateEventPulse, .triggerPulse);
    trigger_source_model far (.mclk, .channel0Pin, .channel1Pin,
        .extTriggerPin, .ch0BothEdgeSignal, .internalTrigger);
    initial
    begin
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails++;
            summarize();
        end
    end
    task automatic summarize();
        if (fails == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task automatic check(input logic [DATA_W-1:0] got, exp, input string m);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask : check
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask : tick
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask : rd
    // configure stopped, soft update, start
    task automatic prep(input logic [DATA_W-1:0] cfg, md, trg, lim);
        wr(OFS_CNT_CFG, 0);
        wr(OFS_MODE_CFG, md);
        wr(OFS_TRIG_CFG, trg);
        wr(OFS_RELOAD, lim);
        wr(OFS_PRESCALER, 0);
        wr(OFS_EVENT_GEN, 1);
        wr(OFS_STATUS, 3);
        wr(OFS_CNT_CFG, cfg);
    endtask : prep
    // cycles between two pulses of bit b
    task automatic gap(input int b, output int n);
        int k;
        repeat (3) tick();
        for (k = 0; pulses[b] !== 1'b1 && k < 600; k++)
            tick();
        tick();
        for (n = 1; pulses[b] !== 1'b1 && n < 600; n++)
            tick();
    endtask : gap
    task automatic watch(output logic t, u);
        {t, u} = 2'b00;
        repeat (12)
        begin
            tick();
            t |= triggerPulse;
            u |= updateEventPulse;
        end
    endtask : watch
    task automatic t_soft();
        int cf [3] = '{0, 4, 7};
        int ex [3] = '{0, 3, 0};
        rd(8'h20);
        check(d, 0, "unmapped read");
        for (int i = 0; i < 3; i++)
        begin
            prep(cf[i], 0, 0, 3);
            wr(OFS_COUNTER, 2);
            wr(OFS_EVENT_GEN, 1);
            rd(OFS_COUNTER);
            check(d, ex[i], "soft load");
        end
        rd(OFS_CNT_CFG);
        check(d & 4, 0, "center direction");
    endtask : t_soft
    task automatic t_edge();
        int n;
        prep(32'h10, 0, 0, 3);
        gap(0, n);
        check(n, 4, "up period");
        wr(OFS_PRESCALER, 1);
        wr(OFS_EVENT_GEN, 1);
        gap(0, n);
        check(n, 8, "psc period");
        rd(OFS_STATUS);
        check(d & 1, 1, "update flag");
        @(posedge mclk);
        clkEnable <= 1'b0;
        tick();
        d = counterValue;
        repeat (4) tick();
        check(counterValue, d, "frozen");
        @(posedge mclk);
        clkEnable <= 1'b1;
        prep(32'h14, 0, 0, 3);
        gap(1, n);
        check(n, 4, "down period");
    endtask : t_edge
    task automatic t_center();
        int n;
        for (int c = 1; c < 4; c++)
        begin
            prep(32'h10 | c, 0, 0, 3);
            gap(2, n);
            check(n, 3, "center update period");
            gap(c == 1, n);
            wr(OFS_STATUS, 3);
            rd(OFS_STATUS);
            check(d & 1, c == 3, "center flag side");
        end
        gap(0, n);
        check(n, 6, "center period");
    endtask : t_center
    task automatic t_slave();
        logic t, u;
        logic [DATA_W-1:0] v;
        for (int i = 0; i < 2; i++)
        begin
            prep(32'h10 | (i << 3), 4, 1, 32'hFF);
            repeat (40) tick();
            fork
                far.pulse(0, 4, 4);
                watch(t, u);
            join
            rd(OFS_COUNTER);
            check(d < 32'd24, 1, "restart reinit");
            check(u, i == 0, "restart update");
            rd(OFS_STATUS);
            check(d & 2, 2, "trigger flag");
        end
        prep(32'h10, 5, 5, 32'hFF);
        rd(OFS_COUNTER);
        check(d, 0, "paused low");
        far.pulse(4, 6, 0);
        repeat (4) tick();
        rd(OFS_COUNTER);
        v = d;
        repeat (6) tick();
        rd(OFS_COUNTER);
        check(d, v, "paused hold");
        check(v != 0, 1, "counted high");
        prep(0, 6, 2, 32'hFF);
        fork
            far.pulse(1, 4, 4);
            watch(t, u);
        join
        check(t, 1, "trigger pulse");
        rd(OFS_CNT_CFG);
        check(d & 32'h10, 32'h10, "trigger start");
        prep(0, 6, 0, 32'hFF);
        rd(OFS_CNT_CFG);
        check(d & 32'h10, 0, "soft source idle");
    endtask : t_slave
    task automatic t_clocks();
        int md [5] = '{7, 7, 0, 0, 0};
        int tr [5] = '{6, 3, 32'h100, 32'h300, 32'h40100};
        int ex [5] = '{5, 5, 5, 5, 0};
        int qx [3] = '{18, 18, 20};
        for (int i = 0; i < 5; i++)
        begin
            prep(32'h10, md[i], tr[i], 32'hFF);
            repeat (5) far.pulse(i ? 2 : 5, 4, 4);
            repeat (8) tick();
            rd(OFS_COUNTER);
            check(d, ex[i], "edge clock");
        end
        for (int i = 0; i < 3; i++)
        begin
            prep(32'h10, i + 1, 0, 32'hFF);
            wr(OFS_COUNTER, 16);
            far.quad(4);
            repeat (4) tick();
            rd(OFS_COUNTER);
            check(d, qx[i], "encoder count");
        end
    endtask : t_clocks
    initial
    begin
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        t_soft();
        t_edge();
        t_center();
        t_slave();
        t_clocks();
        summarize();
    end
endmodule : timer_core_tb_top
